/* core/srap_device.sv */
// device end: two-wire and four-wire register access target
//
// Functional notes
// - start opens busy period, stop closes it
// - repeated start keeps bus busy, keep tracking
// - eight-bit bytes, each followed by acknowledge
// - receiver pulls data low on ninth clock
// - target may hold clock low; master waits
// - seven-bit address, then direction bit
// - data changes only while clock low
// - write: ack address, index, then data bytes
// - burst write advances index per byte
// - read: index write, repeated start, read address
// - master nack ends read; device releases data
// - address re-evaluated after every repeated start
// - four-wire: chip select low whole transaction
// - serial output released while chip select high
// - four-wire bits travel most significant first
// - sample on rising edge, change on falling
// - peripheral clock at most 8 MHz
// - first byte address, later bytes data
// - address byte: direction bit, then index
// - single and burst four-wire transfers supported
// - address six fixed bits plus select pin
// - config bit disables two-wire port
// - pins shared between both modes
`timescale 1ns/10ps
`include "srap_regs.svh"
module srap_device (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic link_clk_in,
  srap_if.dev link,
  output logic wr_valid_out,
  output logic [6:0] wr_index_out,
  output logic [7:0] wr_data_out,
  output logic bus_busy_out
);
  ////////////////////////////////////////////////////////////////////////////
  // link-domain reset and pin synchronisers
  logic lrst_m_q, lrst_n_q;
  logic [2:0] scl_q, sda_q, cs_q;
  logic [1:0] sa0_q;
  always_ff @(posedge link_clk_in) begin
    lrst_m_q <= rst_n_in;
    lrst_n_q <= lrst_m_q;
  end
  always_ff @(posedge link_clk_in) begin
    if (!lrst_n_q) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      cs_q <= 3'h7;
      sa0_q <= 2'h0;
    end else begin
      scl_q <= {scl_q[1:0], link.scl};
      sda_q <= {sda_q[1:0], link.sda};
      cs_q <= {cs_q[1:0], link.cs_n};
      sa0_q <= {sa0_q[0], link.sdo};
    end
  end
  logic scl_rise, scl_fall, start_det, stop_det, spi_act, cs_fall, i2c_en;
  assign scl_rise = scl_q[1] & ~scl_q[2];
  assign scl_fall = ~scl_q[1] & scl_q[2];
  assign start_det = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign stop_det = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
  assign spi_act = ~cs_q[1];
  assign cs_fall = ~cs_q[1] & cs_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // register store and engine state
  srap_pkg::srap_byte_t mem [`SRAP_REG_COUNT];
  srap_pkg::srap_dev_state_e st_q;
  srap_pkg::srap_byte_t rx_q, tx_q;
  srap_pkg::srap_index_t index_q;
  logic [3:0] bitc_q, stretch_q;
  logic rw_q, idx_pend_q, spi_data_q, mack_q, busy_q;
  logic sda_oe_q, scl_oe_q, sdo_q, sdo_oe_q;
  srap_pkg::srap_byte_t rx_next;
  assign rx_next = {rx_q[6:0], sda_q[1]};
  assign i2c_en = cs_q[1] & ~mem[`SRAP_CFG_INDEX][`SRAP_CFG_DIS_BIT];

  logic i2c_wr, spi_wr, wr_go;
  srap_pkg::srap_byte_t wr_dat;
  assign i2c_wr = i2c_en & ~start_det & ~stop_det & (st_q == srap_pkg::SRAP_D_WRDATA)
                & scl_fall & (bitc_q == `SRAP_ACK_BIT) & ~idx_pend_q;
  assign spi_wr = spi_act & ~cs_fall & scl_rise & (bitc_q == `SRAP_LAST_BIT)
                & spi_data_q & (rw_q == `SRAP_WR);
  assign wr_go = i2c_wr | spi_wr;
  assign wr_dat = spi_act ? rx_next : rx_q;

  always_ff @(posedge link_clk_in) begin
    if (!lrst_n_q) begin
      for (int i = 0; i < `SRAP_REG_COUNT; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (wr_go) begin
      mem[index_q] <= wr_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protocol engine
  always_ff @(posedge link_clk_in) begin
    if (!lrst_n_q) begin
      st_q <= srap_pkg::SRAP_D_IDLE;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      index_q <= 7'h00;
      bitc_q <= 4'h0;
      stretch_q <= 4'h0;
      rw_q <= `SRAP_WR;
      idx_pend_q <= 1'b0;
      spi_data_q <= 1'b0;
      mack_q <= 1'b1;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else if (spi_act) begin
      st_q <= srap_pkg::SRAP_D_IDLE;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sdo_oe_q <= 1'b1;
      if (cs_fall) begin
        bitc_q <= 4'h0;
        spi_data_q <= 1'b0;
      end else if (scl_rise) begin
        rx_q <= rx_next;
        bitc_q <= (bitc_q == `SRAP_LAST_BIT) ? 4'h0 : bitc_q + 4'h1;
        if (bitc_q == `SRAP_LAST_BIT) begin
          spi_data_q <= 1'b1;
          if (!spi_data_q) begin
            rw_q <= rx_next[7];
            index_q <= rx_next[6:0];
            if (rx_next[7] == `SRAP_RD) begin
              tx_q <= mem[rx_next[6:0]];
              index_q <= rx_next[6:0] + 7'h1;
            end
          end else begin
            index_q <= index_q + 7'h1;
            if (rw_q == `SRAP_RD) begin
              tx_q <= mem[index_q];
            end
          end
        end
      end else if (scl_fall) begin
        sdo_q <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end else if (!i2c_en) begin
      st_q <= srap_pkg::SRAP_D_IDLE;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else if (stop_det) begin
      st_q <= srap_pkg::SRAP_D_IDLE;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else if (start_det) begin
      st_q <= srap_pkg::SRAP_D_ADDR;
      bitc_q <= 4'h0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      sdo_oe_q <= 1'b0;
      unique case (st_q)
        srap_pkg::SRAP_D_IDLE: begin
        end
        srap_pkg::SRAP_D_ADDR, srap_pkg::SRAP_D_WRDATA: begin
          if (scl_rise) begin
            rx_q <= rx_next;
            bitc_q <= bitc_q + 4'h1;
          end else if (scl_fall && bitc_q == `SRAP_ACK_BIT) begin
            bitc_q <= 4'h0;
            if (st_q == srap_pkg::SRAP_D_ADDR) begin
              if (rx_q[7:1] == {`SRAP_I2C_BASE, sa0_q[1]}) begin
                sda_oe_q <= 1'b1;
                rw_q <= rx_q[0];
                idx_pend_q <= ~rx_q[0];
                st_q <= srap_pkg::SRAP_D_ACK;
              end else begin
                st_q <= srap_pkg::SRAP_D_IDLE;
              end
            end else begin
              sda_oe_q <= 1'b1;
              st_q <= srap_pkg::SRAP_D_ACK;
              idx_pend_q <= 1'b0;
              if (idx_pend_q) begin
                index_q <= rx_q[6:0];
              end else begin
                index_q <= index_q + 7'h1;
              end
            end
          end
        end
        srap_pkg::SRAP_D_ACK: begin
          if (scl_fall) begin
            sda_oe_q <= 1'b0;
            if (rw_q == `SRAP_RD) begin
              scl_oe_q <= 1'b1;
              stretch_q <= `SRAP_STRETCH_CYC;
              st_q <= srap_pkg::SRAP_D_STRETCH;
            end else begin
              st_q <= srap_pkg::SRAP_D_WRDATA;
            end
          end
        end
        srap_pkg::SRAP_D_STRETCH: begin
          stretch_q <= stretch_q - 4'h1;
          if (stretch_q == 4'h0) begin
            scl_oe_q <= 1'b0;
            tx_q <= {mem[index_q][6:0], 1'b0};
            sda_oe_q <= ~mem[index_q][7];
            index_q <= index_q + 7'h1;
            bitc_q <= 4'h0;
            st_q <= srap_pkg::SRAP_D_RDDATA;
          end
        end
        srap_pkg::SRAP_D_RDDATA: begin
          if (scl_rise) begin
            bitc_q <= bitc_q + 4'h1;
          end else if (scl_fall) begin
            if (bitc_q == `SRAP_ACK_BIT) begin
              sda_oe_q <= 1'b0;
              st_q <= srap_pkg::SRAP_D_MACK;
            end else begin
              sda_oe_q <= ~tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
        end
        srap_pkg::SRAP_D_MACK: begin
          if (scl_rise) begin
            mack_q <= sda_q[1];
          end else if (scl_fall) begin
            if (!mack_q) begin
              scl_oe_q <= 1'b1;
              stretch_q <= `SRAP_STRETCH_CYC;
              st_q <= srap_pkg::SRAP_D_STRETCH;
            end else begin
              st_q <= srap_pkg::SRAP_D_IDLE;
            end
          end
        end
        default: begin
          st_q <= srap_pkg::SRAP_D_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (!lrst_n_q) begin
      busy_q <= 1'b0;
    end else if (start_det) begin
      busy_q <= 1'b1;
    end else if (stop_det) begin
      busy_q <= 1'b0;
    end
  end

  assign link.scl_d_o = 1'b0;
  assign link.scl_d_oe = scl_oe_q;
  assign link.sda_d_o = 1'b0;
  assign link.sda_d_oe = sda_oe_q;
  assign link.sdo_d_o = sdo_q;
  assign link.sdo_d_oe = sdo_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // write events cross to the mclk domain by toggle
  logic wr_tgl_q;
  srap_pkg::srap_index_t wr_idx_hold_q;
  srap_pkg::srap_byte_t wr_dat_hold_q;
  always_ff @(posedge link_clk_in) begin
    if (!lrst_n_q) begin
      wr_tgl_q <= 1'b0;
      wr_idx_hold_q <= 7'h00;
      wr_dat_hold_q <= 8'h00;
    end else if (wr_go) begin
      wr_tgl_q <= ~wr_tgl_q;
      wr_idx_hold_q <= index_q;
      wr_dat_hold_q <= wr_dat;
    end
  end
  logic [2:0] tgl_q;
  logic [1:0] busy_s_q;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      tgl_q <= 3'h0;
      busy_s_q <= 2'h0;
      bus_busy_out <= 1'b0;
      wr_valid_out <= 1'b0;
      wr_index_out <= 7'h00;
      wr_data_out <= 8'h00;
    end else begin
      tgl_q <= {tgl_q[1:0], wr_tgl_q};
      busy_s_q <= {busy_s_q[0], busy_q};
      bus_busy_out <= busy_s_q[1];
      wr_valid_out <= tgl_q[1] ^ tgl_q[2];
      if (tgl_q[1] ^ tgl_q[2]) begin
        wr_index_out <= wr_idx_hold_q;
        wr_data_out <= wr_dat_hold_q;
      end
    end
  end
endmodule // srap_device

/* core/srap_host.sv */
// host end: bus master for two-wire and four-wire register access
`timescale 1ns/10ps
`include "srap_regs.svh"
module srap_host #(
  parameter int SPI_QTR = `SRAP_SPI_QTR_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  srap_if.host link,
  input wire logic req_in,
  input wire logic req_spi_in,
  input wire logic req_read_in,
  input wire logic req_sel_in,
  input wire logic [6:0] req_index_in,
  input wire logic [2:0] req_count_in,
  input wire logic [31:0] req_wdata_in,
  output logic busy_out,
  output logic done_out,
  output logic nack_out,
  output logic [31:0] rdata_out
);
  localparam int I2C_QTR = `SRAP_MCLK_KHZ / (`SRAP_I2C_KHZ * 4);
  localparam int SPI_QMIN = (`SRAP_MCLK_KHZ + `SRAP_SPI_MAX_KHZ * 4 - 1)
                          / (`SRAP_SPI_MAX_KHZ * 4);
  localparam int SPI_QUSE = (SPI_QTR < SPI_QMIN) ? SPI_QMIN : SPI_QTR;

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] scl_q, sda_q, sdo_q;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      scl_q <= 2'h3;
      sda_q <= 2'h3;
      sdo_q <= 2'h3;
    end else begin
      scl_q <= {scl_q[0], link.scl};
      sda_q <= {sda_q[0], link.sda};
      sdo_q <= {sdo_q[0], link.sdo};
    end
  end

  srap_pkg::srap_host_state_e st_q;
  logic spi_q, rd_q, sel_q, ack_seen_q, scl_lvl_q, sda_lvl_q, cs_lvl_q;
  logic [6:0] idx_q;
  logic [2:0] cnt_q, seg_q;
  logic [31:0] wdata_q;
  logic [7:0] sh_q, rsh_q, div_q, qlim;
  logic [1:0] q_q;
  logic [3:0] bitc_q;
  logic [2:0] first_seg, last_seg, k;
  logic rx, stall, bit_out;
  assign first_seg = spi_q ? 3'h1 : (rd_q ? 3'h3 : 3'h2);
  assign last_seg = first_seg + cnt_q - 3'h1;
  assign k = seg_q - first_seg;
  assign rx = rd_q & (seg_q >= first_seg);
  assign qlim = spi_q ? 8'(SPI_QUSE - 1) : 8'(I2C_QTR - 1);
  assign stall = (q_q == 2'h2) & ~spi_q & ~scl_q[1];
  assign bit_out = (bitc_q == `SRAP_ACK_BIT) ? (~rx | (seg_q == last_seg))
                 : (rx | sh_q[7]);

  function automatic srap_pkg::srap_byte_t tx_byte(input logic [2:0] seg);
    logic [2:0] d;
    d = seg - first_seg;
    if (spi_q && seg == 3'h0) begin
      tx_byte = {rd_q, idx_q};
    end else if (!spi_q && seg == 3'h0) begin
      tx_byte = {`SRAP_I2C_BASE, sel_q, `SRAP_WR};
    end else if (!spi_q && seg == 3'h1) begin
      tx_byte = {1'b0, idx_q};
    end else if (!spi_q && rd_q && seg == 3'h2) begin
      tx_byte = {`SRAP_I2C_BASE, sel_q, `SRAP_RD};
    end else begin
      tx_byte = wdata_q[{d[1:0], 3'h0} +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st_q <= srap_pkg::SRAP_H_IDLE;
      {spi_q, rd_q, sel_q, ack_seen_q} <= 4'h0;
      {scl_lvl_q, sda_lvl_q, cs_lvl_q} <= 3'h7;
      idx_q <= 7'h00;
      cnt_q <= 3'h1;
      seg_q <= 3'h0;
      wdata_q <= 32'h0;
      {sh_q, rsh_q, div_q} <= 24'h0;
      q_q <= 2'h0;
      bitc_q <= 4'h0;
      {busy_out, done_out, nack_out} <= 3'h0;
      rdata_out <= 32'h0;
    end else if (st_q == srap_pkg::SRAP_H_IDLE) begin
      done_out <= 1'b0;
      if (req_in) begin
        {spi_q, rd_q, sel_q} <= {req_spi_in, req_read_in, req_sel_in};
        idx_q <= req_index_in;
        cnt_q <= req_count_in;
        wdata_q <= req_wdata_in;
        {seg_q, q_q, div_q} <= 13'h0;
        {busy_out, nack_out} <= 2'h2;
        st_q <= srap_pkg::SRAP_H_START;
      end
    end else if (st_q == srap_pkg::SRAP_H_DONE) begin
      busy_out <= 1'b0;
      done_out <= 1'b1;
      st_q <= srap_pkg::SRAP_H_IDLE;
    end else if (stall) begin
      div_q <= 8'h0;
    end else if (div_q != qlim) begin
      div_q <= div_q + 8'h1;
    end else begin
      div_q <= 8'h0;
      q_q <= q_q + 2'h1;
      unique case ({st_q, q_q})
        {srap_pkg::SRAP_H_START, 2'h0}: begin
          sda_lvl_q <= 1'b1;
          cs_lvl_q <= ~spi_q;
        end
        {srap_pkg::SRAP_H_START, 2'h2}: sda_lvl_q <= spi_q;
        {srap_pkg::SRAP_H_START, 2'h3}: begin
          scl_lvl_q <= 1'b0;
          bitc_q <= 4'h0;
          sh_q <= tx_byte(seg_q);
          st_q <= srap_pkg::SRAP_H_BIT;
        end
        {srap_pkg::SRAP_H_BIT, 2'h0}: sda_lvl_q <= bit_out;
        {srap_pkg::SRAP_H_BIT, 2'h2}: begin
          if (bitc_q == `SRAP_ACK_BIT) begin
            ack_seen_q <= sda_q[1];
          end else begin
            rsh_q <= {rsh_q[6:0], spi_q ? sdo_q[1] : sda_q[1]};
          end
        end
        {srap_pkg::SRAP_H_BIT, 2'h3}: begin
          scl_lvl_q <= 1'b0;
          sh_q <= {sh_q[6:0], 1'b0};
          bitc_q <= bitc_q + 4'h1;
          if (bitc_q == (spi_q ? `SRAP_LAST_BIT : `SRAP_ACK_BIT)) begin
            if (rx) begin
              rdata_out[{k[1:0], 3'h0} +: 8] <= rsh_q;
            end
            if (!spi_q && !rx && ack_seen_q) begin
              nack_out <= 1'b1;
              st_q <= srap_pkg::SRAP_H_STOP;
            end else if (seg_q == last_seg) begin
              st_q <= srap_pkg::SRAP_H_STOP;
            end else if (!spi_q && rd_q && seg_q == 3'h1) begin
              seg_q <= seg_q + 3'h1;
              st_q <= srap_pkg::SRAP_H_START;
            end else begin
              seg_q <= seg_q + 3'h1;
              bitc_q <= 4'h0;
              sh_q <= tx_byte(seg_q + 3'h1);
            end
          end
        end
        {srap_pkg::SRAP_H_STOP, 2'h0}: sda_lvl_q <= spi_q;
        {srap_pkg::SRAP_H_STOP, 2'h2}: sda_lvl_q <= 1'b1;
        {srap_pkg::SRAP_H_STOP, 2'h3}: begin
          cs_lvl_q <= 1'b1;
          st_q <= srap_pkg::SRAP_H_DONE;
        end
        default: begin
          if (q_q == 2'h1) begin
            scl_lvl_q <= 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins: push-pull while selected in four-wire mode, open-drain otherwise
  logic spi_on;
  assign spi_on = spi_q & ~cs_lvl_q;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      {link.scl_h_o, link.scl_h_oe, link.sda_h_o, link.sda_h_oe} <= 4'h0;
      link.cs_n <= 1'b1;
    end else begin
      link.scl_h_oe <= spi_on | ~scl_lvl_q;
      link.scl_h_o <= spi_on & scl_lvl_q;
      link.sda_h_oe <= spi_on | ~sda_lvl_q;
      link.sda_h_o <= spi_on & sda_lvl_q;
      link.cs_n <= cs_lvl_q;
    end
  end
endmodule // srap_host

/* core/srap_if.sv */
// shared pins between host and device, with pull-up resolution
`timescale 1ns/10ps
interface srap_if;
  logic scl_h_o, scl_h_oe, sda_h_o, sda_h_oe, cs_n;
  logic scl_d_o, scl_d_oe, sda_d_o, sda_d_oe, sdo_d_o, sdo_d_oe;
  logic sa0_strap;
  logic scl, sda, sdo;
  // scl and sda are low when any enabled driver pulls them low, else pulled high
  assign scl = ((scl_h_oe & ~scl_h_o) | (scl_d_oe & ~scl_d_o)) ? 1'b0 : 1'b1;
  assign sda = ((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o)) ? 1'b0 : 1'b1;
  assign sdo = sdo_d_oe ? sdo_d_o : sa0_strap;
  modport dev (input scl, sda, cs_n, sdo,
               output scl_d_o, scl_d_oe, sda_d_o, sda_d_oe, sdo_d_o, sdo_d_oe);
  modport host (input scl, sda, sdo, output scl_h_o, scl_h_oe, sda_h_o, sda_h_oe, cs_n);
endinterface

/* core/srap_pkg.sv */
// types for the serial register access port
package srap_pkg;
  typedef logic [7:0] srap_byte_t;
  typedef logic [6:0] srap_index_t;
  typedef enum logic [2:0] {
    SRAP_D_IDLE = 3'b000,
    SRAP_D_ADDR = 3'b001,
    SRAP_D_WRDATA = 3'b010,
    SRAP_D_ACK = 3'b011,
    SRAP_D_STRETCH = 3'b100,
    SRAP_D_RDDATA = 3'b101,
    SRAP_D_MACK = 3'b110
  } srap_dev_state_e;
  typedef enum logic [2:0] {
    SRAP_H_IDLE = 3'b000,
    SRAP_H_START = 3'b001,
    SRAP_H_BIT = 3'b010,
    SRAP_H_STOP = 3'b011,
    SRAP_H_DONE = 3'b100
  } srap_host_state_e;
endpackage

/* core/srap_regs.svh */
// constants for the serial register access port
`ifndef SRAP_REGS_SVH
`define SRAP_REGS_SVH
`define SRAP_I2C_BASE 6'h34
`define SRAP_CFG_INDEX 7'h6a
`define SRAP_CFG_DIS_BIT 4
`define SRAP_STRETCH_CYC 4'h4
`define SRAP_MCLK_KHZ 40000
`define SRAP_I2C_KHZ 400
`define SRAP_SPI_MAX_KHZ 8000
`define SRAP_SPI_QTR_CYC 8
`define SRAP_LAST_BIT 4'h7
`define SRAP_ACK_BIT 4'h8
`define SRAP_REG_COUNT 128
`define SRAP_RD 1'b1
`define SRAP_WR 1'b0
`endif

/* verif/srap_props.sv */
// concurrent checks on the shared pins between host and device
`timescale 1ns/10ps
module srap_props (
  input wire logic link_clk_in,
  input wire logic rst_n_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic cs_n,
  input wire logic scl_d_oe,
  input wire logic sda_d_oe,
  input wire logic sdo_d_o,
  input wire logic sdo_d_oe
);
  default clocking cb @(posedge link_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  AST_SDO_RELEASE: assert property (cs_n [*4] |-> !sdo_d_oe)
    else $error("serial output driven while chip select high");
  AST_SDO_DRIVE: assert property (!cs_n [*6] |-> sdo_d_oe)
    else $error("serial output not driven while selected");
  AST_SDA_CHANGE: assert property ($changed(sda_d_oe) |-> !scl)
    else $error("device data changed while clock high");
  AST_SDO_CHANGE: assert property ((!cs_n && !$past(cs_n, 8) && $changed(sdo_d_o)) |-> !scl)
    else $error("serial output changed while clock high");
  AST_ACK_HOLD: assert property ((sda_d_oe && $rose(scl)) |-> sda_d_oe [*8])
    else $error("device released data during clock high");
  AST_STRETCH: assert property ($rose(scl_d_oe) |-> ##[1:8] !scl_d_oe)
    else $error("clock held low too long");
  AST_FOUR_WIRE: assert property (!cs_n [*4] |-> (!sda_d_oe && !scl_d_oe))
    else $error("two-wire drive while chip select low");
  AST_STOP: assert property ((scl && $rose(sda)) |-> !sda_d_oe [*4])
    else $error("device drives data after stop");
endmodule // srap_props

/* verif/test_serial_register_access_port.sv */
// self-checking bench joining host and device ends over the shared pins
`timescale 1ns/10ps
`include "srap_regs.svh"
module test_serial_register_access_port;
  logic mclk_in = 1'b0;
  logic link_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic req_in = 1'b0, req_spi_in = 1'b0, req_read_in = 1'b0, req_sel_in = 1'b0;
  logic [6:0] req_index_in = 7'h00;
  logic [2:0] req_count_in = 3'h1;
  logic [31:0] req_wdata_in = 32'h0;
  logic busy_out, done_out, nack_out, wr_valid_out, bus_busy_out;
  logic [31:0] rdata_out;
  logic [6:0] wr_index_out;
  logic [7:0] wr_data_out;
  logic [7:0] mem [128] = '{default: 8'h00};
  logic [6:0] next_idx = 7'h00;
  logic [31:0] seed = 32'ha872;
  int error_cnt = 0, check_count = 0, pend = 0;
  srap_if link_if ();
  initial link_if.sa0_strap = 1'b0;
  initial begin
    forever #12.5 mclk_in = ~mclk_in;
  end
  initial begin
    #7.3;
    forever #16 link_clk_in = ~link_clk_in;
  end
  srap_device u_srap_device (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk_in),
    .link(link_if), .wr_valid_out(wr_valid_out), .wr_index_out(wr_index_out),
    .wr_data_out(wr_data_out), .bus_busy_out(bus_busy_out));
  srap_host #(.SPI_QTR(8)) u_srap_host (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .link(link_if),
    .req_in(req_in), .req_spi_in(req_spi_in), .req_read_in(req_read_in), .req_sel_in(req_sel_in),
    .req_index_in(req_index_in), .req_count_in(req_count_in), .req_wdata_in(req_wdata_in),
    .busy_out(busy_out), .done_out(done_out), .nack_out(nack_out), .rdata_out(rdata_out));
  srap_props u_srap_props (.link_clk_in(link_clk_in), .rst_n_in(rst_n_in), .scl(link_if.scl),
    .sda(link_if.sda), .cs_n(link_if.cs_n), .scl_d_oe(link_if.scl_d_oe),
    .sda_d_oe(link_if.sda_d_oe), .sdo_d_o(link_if.sdo_d_o), .sdo_d_oe(link_if.sdo_d_oe));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] mask(input logic [2:0] cnt);
    return (32'h1 << (8 * cnt)) - 32'h1;
  endfunction
  // expected read word from the bench copy of the store, index wrapping
  function automatic logic [31:0] exp_rd(input logic [6:0] idx, input logic [2:0] cnt);
    logic [31:0] w;
    w = 32'h0;
    for (int k = 0; k < cnt; k++) begin
      w[8*k +: 8] = mem[7'(idx + k)];
    end
    return w;
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  always @(negedge mclk_in) begin
    if (wr_valid_out === 1'b1) begin
      check("wr_expected", 32'(pend > 0), 32'h1);
      check("wr_index", 32'(wr_index_out), 32'(next_idx));
      check("wr_data", 32'(wr_data_out), 32'(mem[next_idx]));
      next_idx = next_idx + 7'h1;
      pend = pend - 1;
    end
  end
  task automatic xfer(input logic spi, input logic rd, input logic sel, input logic [6:0] idx,
                      input logic [2:0] cnt, input logic [31:0] wd, input logic bad);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    @(negedge mclk_in);
    req_in = 1'b1;
    req_spi_in = spi;
    req_read_in = rd;
    req_sel_in = sel;
    req_index_in = idx;
    req_count_in = cnt;
    req_wdata_in = wd;
    if (!rd && !bad) begin
      next_idx = idx;
      pend = cnt;
      for (int k = 0; k < cnt; k++) begin
        mem[7'(idx + k)] = wd[8*k +: 8];
      end
    end
    @(negedge mclk_in);
    req_in = 1'b0;
    check("busy_out", 32'(busy_out), 32'h1);
    while (done_out !== 1'b1 && n < 30000) begin
      @(negedge mclk_in);
      n++;
      seen = seen | bus_busy_out;
    end
    if (n >= 30000) begin
      error_cnt++;
      final_report();
    end
    check("busy_done", 32'(busy_out), 32'h0);
    check("nack", 32'(nack_out), 32'(bad));
    if (rd && !bad) check("rdata", rdata_out & mask(cnt), exp_rd(idx, cnt));
    if (!spi && !bad) check("busy_seen", 32'(seen), 32'h1);
    repeat (40) @(negedge mclk_in);
    check("wr_left", 32'(pend), 32'h0);
    if (!spi) check("busy_idle", 32'(bus_busy_out), 32'h0);
  endtask
  ////////////////////////////////////////
  initial begin
    logic [2:0] cnt;
    logic [6:0] idx;
    repeat (8) @(negedge mclk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    // write in one mode, read back in the other; first case wraps past the top index
    for (int t = 0; t < 10; t++) begin
      seed = lfsr(seed);
      cnt = (t == 0) ? 3'h4 : (t == 1) ? 3'h1 : 3'(seed[1:0]) + 3'h1;
      idx = (t == 0) ? 7'h7e : {1'b0, seed[13:8]};
      if (t == 5) link_if.sa0_strap = 1'b1;
      seed = lfsr(seed);
      xfer(1'(t), 1'b0, link_if.sa0_strap, idx, cnt, seed, 1'b0);
      xfer(~1'(t), 1'b1, link_if.sa0_strap, idx, cnt, 32'h0, 1'b0);
      $display("test %0d done", t);
    end
    // other select level: target stays silent
    xfer(1'b0, 1'b0, ~link_if.sa0_strap, 7'h10, 3'h2, 32'h5aa5, 1'b1);
    xfer(1'b0, 1'b1, ~link_if.sa0_strap, 7'h10, 3'h1, 32'h0, 1'b1);
    $display("test address done");
    // disable the two-wire port over four-wire, then two-wire is refused
    xfer(1'b1, 1'b0, 1'b0, `SRAP_CFG_INDEX, 3'h1, 32'(1 << `SRAP_CFG_DIS_BIT), 1'b0);
    xfer(1'b0, 1'b1, link_if.sa0_strap, 7'h10, 3'h1, 32'h0, 1'b1);
    xfer(1'b1, 1'b1, 1'b0, 7'h7e, 3'h4, 32'h0, 1'b0);
    $display("test disable done");
    final_report();
  end
endmodule // test_serial_register_access_port
